// >>> design/gpreg_ports.sv
// general purpose port register bank for ports a to g
`timescale 1ns/1ps
`include "gpreg_consts.svh"
//------------------------------------------------------------------
// Behaviour
// - each port has a read-only byte sampling its pins; writes ignored
// - ports b to g have a read/write data byte resetting to zero
// - ports b to g have a read/write direction byte resetting to zero
// - port g bits 7 to 5 are absent and read as zero
// - legacy mode starts port c as push-pull zero outputs
// - legacy port c reset state holds without any clock edge
// - legacy mode removes port f data and direction; input only
// - legacy mode hides all port g registers
// - legacy port g pins carry only their alternate functions
// - input pin with data one gets pull-up unless globally disabled
//------------------------------------------------------------------
module gpreg_ports
  import gpreg_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        legacy_mode_i,
  input  wire gpreg_addr_t addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o,
  input  wire gpreg_bank_t pin_in_i,
  input  wire logic        mem_wr_n_i,
  input  wire logic        mem_rd_n_i,
  input  wire logic        mem_ale_i,
  output gpreg_bank_t      pin_out_o,
  output gpreg_bank_t      pin_oe_o,
  output gpreg_bank_t      pullup_en_o
);

  //----------------------------------------------------------------
  // elaboration check
  //----------------------------------------------------------------

  // the bank layout is fixed at one byte per port
  if (PORT_W != 8) begin : g_bad_width
    $error("gpreg_ports supports only 8-bit ports");
  end

  //----------------------------------------------------------------
  // shared state
  //----------------------------------------------------------------

  logic        global_pullup_disable;
  gpreg_bank_t sample_q;
  gpreg_bank_t data_b;
  gpreg_bank_t dir_b;
  gpreg_bank_t pin_b;
  gpreg_bank_t oe_b;
  gpreg_bank_t out_b;
  gpreg_bank_t pu_b;
  logic [7:0]  next_rdata;

  // pins are synchronous; one flop gives a stable read value
  // no reset: the sampled value is undefined until first clock
  always_ff @(posedge mclk_i) begin
    sample_q <= pin_in_i;
  end

  // global pull-up disable in the control register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      global_pullup_disable <= 1'b0;
    end else if (wr_i && addr_i == `GPREG_CTRL_ADDR) begin
      global_pullup_disable <= wdata_i[`GPREG_PUD_BIT];
    end
  end

  //----------------------------------------------------------------
  // per-port registers and pin drive
  //----------------------------------------------------------------

  for (genvar p = 0; p < 7; p++) begin : g_port
    // per-port constants, fixed at elaboration
    localparam logic [2:0] IDX  = 3'(p);
    localparam logic [7:0] MASK =
      (p == 6) ? `GPREG_G_MASK : `GPREG_FULL_MASK;
    localparam bit HAS_DD = (p != 0);
    localparam bit IS_C   = (IDX == `GPREG_PORT_C);
    localparam bit IS_G   = (IDX == `GPREG_PORT_G);
    localparam bit LEG_DD =
      (IDX == `GPREG_PORT_F) || (IDX == `GPREG_PORT_G);

    // storage and next-state values of this port
    logic       dd_ok;
    logic       pin_ok;
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] next_oe;
    logic [7:0] next_out;
    logic [7:0] next_pu;
    logic [7:0] oe_q;
    logic [7:0] out_q;
    logic [7:0] pu_q;

    // availability of this port's registers in the current mode
    assign dd_ok  = HAS_DD && !(legacy_mode_i && LEG_DD);
    assign pin_ok = !(legacy_mode_i && IS_G);

    // data byte; absent bits never store a one
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        data <= `GPREG_DATA_RST;
      end else if (wr_i && dd_ok &&
                   addr_i == {IDX, `GPREG_FLD_DATA}) begin
        data <= wdata_i & MASK;
      end
    end

    // direction byte; legacy port c wakes up as all outputs
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        if (IS_C && legacy_mode_i) begin
          dir <= `GPREG_LEGACY_DIR_C;
        end else begin
          dir <= `GPREG_DIR_RST;
        end
      end else if (wr_i && dd_ok &&
                   addr_i == {IDX, `GPREG_FLD_DIR}) begin
        dir <= wdata_i & MASK;
      end
    end

    // software view; hidden registers read as zero
    assign data_b[p] = dd_ok ? data : 8'h00;
    assign dir_b[p]  = dd_ok ? dir : 8'h00;
    assign pin_b[p]  = pin_ok ? (sample_q[p] & MASK) : 8'h00;

    // pin drive from the registers, or alternate functions
    always_comb begin
      next_oe  = dd_ok ? (dir & MASK) : 8'h00;
      next_out = dd_ok ? (data & dir & MASK) : 8'h00;
      next_pu  = 8'h00;
      if (dd_ok && !global_pullup_disable) begin
        next_pu = ~dir & data & MASK;
      end
      if (IS_G && legacy_mode_i) begin
        // memory strobes on bits 2..0; oscillator pins left undriven
        next_oe  = `GPREG_G_ALT_OE;
        next_out = {5'h00, mem_ale_i, mem_rd_n_i, mem_wr_n_i};
      end
    end

    // registered pin drive keeps glitches off the pads
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        oe_q  <= 8'h00;
        out_q <= 8'h00;
        pu_q  <= 8'h00;
      end else begin
        oe_q  <= next_oe;
        out_q <= next_out;
        pu_q  <= next_pu;
      end
    end

    // software-side copies of the drive flops
    assign oe_b[p]  = oe_q;
    assign out_b[p] = out_q;
    assign pu_b[p]  = pu_q;

    // legacy port c must hold push-pull zero with no clock at all,
    // so its enable bypasses the drive flops from the fuse, and its level does so while reset is held
    if (IS_C) begin : g_legacy_c
      assign pin_oe_o[p]  = legacy_mode_i ? 8'hff : oe_q;
      assign pin_out_o[p] = (legacy_mode_i && rst_i) ? 8'h00 : out_q;
    end else begin : g_plain
      assign pin_oe_o[p]  = oe_q;
      assign pin_out_o[p] = out_q;
    end
  end

  // pull-ups have no legacy override, so the flops feed the pins
  assign pullup_en_o = pu_b;

  //----------------------------------------------------------------
  // register read path
  //----------------------------------------------------------------

  // unmapped and absent addresses answer zero
  // port index 7 carries only the control byte at field 3
  always_comb begin
    next_rdata = 8'h00;
    if (addr_i == `GPREG_CTRL_ADDR) begin
      next_rdata[`GPREG_PUD_BIT]    = global_pullup_disable;
      next_rdata[`GPREG_LEGACY_BIT] = legacy_mode_i;
    end else if (addr_i[4:2] <= `GPREG_PORT_LAST) begin
      case (addr_i[1:0])
        `GPREG_FLD_PIN:  next_rdata = pin_b[addr_i[4:2]];
        `GPREG_FLD_DIR:  next_rdata = dir_b[addr_i[4:2]];
        `GPREG_FLD_DATA: next_rdata = data_b[addr_i[4:2]];
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------

  localparam gpreg_addr_t B_DATA = {`GPREG_PORT_B, `GPREG_FLD_DATA};
  localparam gpreg_addr_t B_PIN  = {`GPREG_PORT_B, `GPREG_FLD_PIN};
  localparam gpreg_addr_t F_DIR  = {`GPREG_PORT_F, `GPREG_FLD_DIR};
  localparam gpreg_addr_t B_DIR  = {`GPREG_PORT_B, `GPREG_FLD_DIR};
  localparam gpreg_addr_t A_PIN  = {`GPREG_PORT_A, `GPREG_FLD_PIN};
  localparam gpreg_addr_t F_PIN  = {`GPREG_PORT_F, `GPREG_FLD_PIN};
  localparam gpreg_addr_t G_DATA = {`GPREG_PORT_G, `GPREG_FLD_DATA};
  localparam gpreg_addr_t G_DIR  = {`GPREG_PORT_G, `GPREG_FLD_DIR};

  // all checks run on the one clock; reset masks all but legacy_c_clockless_a
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_write_b;
    wr_i && addr_i == B_DATA;
  endsequence

  sequence s_read_b;
    rd_i && !wr_i && addr_i == B_DATA;
  endsequence

  sequence s_pud_set;
    wr_i && addr_i == `GPREG_CTRL_ADDR && wdata_i[`GPREG_PUD_BIT];
  endsequence

  // a written data byte reads back one cycle after the read strobe
  data_readback_a: assert property (
    s_write_b ##1 s_read_b |=> rdata_o == $past(wdata_i, 2))
    else $error("data byte did not read back");

  // sampled pins appear two cycles after they were driven
  pin_sample_a: assert property (
    rd_i && addr_i == B_PIN |=> rdata_o == $past(pin_in_i[1], 2))
    else $error("pin sample read wrong");

  // data bytes are zero right after reset
  reset_data_a: assert property (
    $fell(rst_i) |-> data_b == '0)
    else $error("data byte not zero after reset");

  // all pins start as inputs outside legacy mode
  reset_dir_a: assert property (
    $fell(rst_i) && !legacy_mode_i |-> dir_b == '0 && pin_oe_o == '0)
    else $error("direction not input after reset");

  // port g upper bits stay zero in data, direction, pin sample and output enable
  g_upper_bits_a: assert property (
    data_b[6][7:5] == 3'h0 && dir_b[6][7:5] == 3'h0 &&
    pin_b[6][7:5] == 3'h0 && pin_oe_o[6][7:5] == 3'h0)
    else $error("port g upper bits not zero");

  // legacy port c leaves reset as driven outputs at zero
  legacy_c_init_a: assert property (
    $fell(rst_i) && legacy_mode_i |->
      dir_b[2] == `GPREG_LEGACY_DIR_C && pin_oe_o[2] == 8'hff &&
      pin_out_o[2] == 8'h00)
    else $error("legacy port c not push-pull zero");

  // held during reset itself, so no clock edge is needed
  legacy_c_clockless_a: assert property (
    disable iff (1'b0)
    rst_i && legacy_mode_i |-> pin_oe_o[2] == 8'hff &&
      pin_out_o[2] == 8'h00)
    else $error("legacy port c released in reset");

  // legacy port f never drives or pulls up
  legacy_f_input_a: assert property (
    legacy_mode_i ##1 legacy_mode_i |->
      pin_oe_o[5] == 8'h00 && pullup_en_o[5] == 8'h00)
    else $error("legacy port f driven");

  // legacy port g registers read as zero
  legacy_g_read_a: assert property (
    legacy_mode_i && rd_i && addr_i[4:2] == `GPREG_PORT_G |=>
      rdata_o == 8'h00)
    else $error("legacy port g register visible");

  // legacy port g pins follow the memory strobes
  // the releasing edge still clears the flops, so it starts nothing
  legacy_g_alt_a: assert property (
    legacy_mode_i && !rst_i ##1 legacy_mode_i |->
      pin_oe_o[6] == `GPREG_G_ALT_OE &&
      pin_out_o[6][2:0] ==
        $past({mem_ale_i, mem_rd_n_i, mem_wr_n_i}))
    else $error("legacy port g alternate function wrong");

  // global disable clears every pull-up two cycles later
  pullup_off_a: assert property (
    s_pud_set ##1 !(wr_i && addr_i == `GPREG_CTRL_ADDR) |=>
      pullup_en_o == '0)
    else $error("pull-up left on after global disable");

  // a legacy write to the hidden f direction stores nothing
  legacy_f_write_a: assert property (
    legacy_mode_i && wr_i && addr_i == F_DIR |=>
      g_port[5].dir == $past(g_port[5].dir))
    else $error("hidden register took a write");

  sequence s_write_b_dir;
    wr_i && addr_i == B_DIR;
  endsequence

  sequence s_read_b_dir;
    rd_i && !wr_i && addr_i == B_DIR;
  endsequence

  // a written direction byte reads back one cycle after the read strobe
  dir_readback_a: assert property (
    s_write_b_dir ##1 s_read_b_dir |=> rdata_o == $past(wdata_i, 2))
    else $error("direction byte did not read back");

  // port b pins and pull-ups follow the registers one cycle later
  drive_oe_a: assert property (
    pin_oe_o[1] == $past(dir_b[1]))
    else $error("port b enable does not follow direction");

  drive_out_a: assert property (
    pin_out_o[1] == $past(data_b[1] & dir_b[1]))
    else $error("port b level does not follow data");

  pullup_follow_a: assert property (
    pullup_en_o[1] == $past(~dir_b[1] & data_b[1] & {8{!global_pullup_disable}}))
    else $error("port b pull-up wrong");

  // read data fall back to zero when no read was asked for
  read_idle_a: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside the read cycle");

  // the port a sample byte shows the pins of two cycles earlier
  a_pin_read_a: assert property (
    rd_i && addr_i == A_PIN |=> rdata_o == $past(pin_in_i[0], 2))
    else $error("port a sample read wrong");

  // legacy port f keeps its sample byte readable
  legacy_f_pin_a: assert property (
    legacy_mode_i && rd_i && addr_i == F_PIN |=>
      rdata_o == $past(pin_in_i[5], 2))
    else $error("legacy port f sample read wrong");

  // port g keeps only its five pins in data and direction
  g_data_mask_a: assert property (
    !legacy_mode_i && wr_i && addr_i == G_DATA |=>
      data_b[6] == ($past(wdata_i) & `GPREG_G_MASK))
    else $error("port g data kept absent bits");

  g_dir_mask_a: assert property (
    !legacy_mode_i && wr_i && addr_i == G_DIR |=>
      dir_b[6] == ($past(wdata_i) & `GPREG_G_MASK))
    else $error("port g direction kept absent bits");

  // control byte shows the disable bit and the fuse
  ctrl_readback_a: assert property (
    rd_i && addr_i == `GPREG_CTRL_ADDR |=>
      rdata_o[`GPREG_PUD_BIT] == $past(global_pullup_disable) &&
      rdata_o[`GPREG_LEGACY_BIT] == $past(legacy_mode_i))
    else $error("control byte read wrong");

endmodule // gpreg_ports

// >>> include/gpreg_consts.svh
// offsets, field codes, reset values and masks of the port register bank
`ifndef GPREG_CONSTS_SVH
`define GPREG_CONSTS_SVH

// register address = {port index, field code}
`define GPREG_FLD_PIN      2'h0
`define GPREG_FLD_DIR      2'h1
`define GPREG_FLD_DATA     2'h2
`define GPREG_CTRL_ADDR    5'h1f

// port indices
`define GPREG_PORT_A       3'h0
`define GPREG_PORT_B       3'h1
`define GPREG_PORT_C       3'h2
`define GPREG_PORT_F       3'h5
`define GPREG_PORT_G       3'h6
`define GPREG_PORT_LAST    3'h6

// control register fields
`define GPREG_PUD_BIT      2
`define GPREG_LEGACY_BIT   7

// reset values and masks
`define GPREG_DATA_RST     8'h00
`define GPREG_DIR_RST      8'h00
`define GPREG_LEGACY_DIR_C 8'hff
`define GPREG_FULL_MASK    8'hff
`define GPREG_G_MASK       8'h1f
`define GPREG_G_ALT_OE     8'h07

`endif

// >>> include/gpreg_pkg.sv
// types shared by the port register bank
package gpreg_pkg;

  // one byte per port, ports a (0) to g (6)
  typedef logic [6:0][7:0] gpreg_bank_t;

  typedef logic [4:0] gpreg_addr_t;

endpackage

// >>> verification/gpreg_pin_model.sv
// board-side model of the port pins feeding levels back to the bank
`timescale 1ns/1ps
module gpreg_pin_model
  import gpreg_pkg::*;
(
  input  wire gpreg_bank_t drv_i,
  input  wire gpreg_bank_t oe_i,
  input  wire gpreg_bank_t pu_i,
  input  wire gpreg_bank_t ext_i,
  input  wire gpreg_bank_t ext_en_i,
  output gpreg_bank_t      level_o
);
  // driven pin shows its level; else the board, else pull-up or a flipped level
  assign level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i)
                 | (~oe_i & ~ext_en_i & (pu_i | ~ext_i));
endmodule // gpreg_pin_model

// >>> verification/testbench.sv
// self-checking bench of the port register bank
`timescale 1ns/1ps
module testbench;
  import gpreg_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        legacy_mode_i = 1'b0;
  gpreg_addr_t addr_i = '0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        mem_wr_n_i = 1'b1;
  logic        mem_rd_n_i = 1'b1;
  logic        mem_ale_i = 1'b0;
  gpreg_bank_t ext = '0;
  gpreg_bank_t ext_en = '1;
  gpreg_bank_t pin_in_i;
  gpreg_bank_t pin_out_o;
  gpreg_bank_t pin_oe_o;
  gpreg_bank_t pullup_en_o;
  logic [7:0]  rdata_o;
  logic [7:0]  dv;
  logic [7:0]  wd;
  logic [7:0]  ev;
  logic [7:0]  rv;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;

  always #12.5 mclk_i = ~mclk_i;

  gpreg_ports u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .legacy_mode_i(legacy_mode_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_in_i(pin_in_i), .mem_wr_n_i(mem_wr_n_i), .mem_rd_n_i(mem_rd_n_i),
    .mem_ale_i(mem_ale_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pullup_en_o(pullup_en_o));
  gpreg_pin_model u_pins (.drv_i(pin_out_o), .oe_i(pin_oe_o), .pu_i(pullup_en_o),
    .ext_i(ext), .ext_en_i(ext_en), .level_o(pin_in_i));

  //----------------------------------------------------------
  // helpers
  //----------------------------------------------------------
  function automatic logic [7:0] msk(input int p);
    return (p == 6) ? 8'h1f : 8'hff;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // gap cycle after each strobe keeps one assignment per time step
  task automatic reg_wr(input int p, input logic [1:0] f, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= {p[2:0], f};
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input int p, input logic [1:0] f, output logic [7:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= {p[2:0], f};
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask

  // write then read one register with no gap between the strobes
  task automatic reg_wr_rd(input int p, input logic [1:0] f, input logic [7:0] d,
                           output logic [7:0] q);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= {p[2:0], f};
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    q = rdata_o;
  endtask

  task automatic complete_run();
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the length of the sequence
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  //----------------------------------------------------------
  // sequence
  //----------------------------------------------------------
  initial begin
    dv = $urandom(14036);
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int p = 1; p < 7; p++) begin
      reg_rd(p, 2'h1, rv);
      check("dir reset", rv, 8'h00);
      reg_rd(p, 2'h2, rv);
      check("data reset", rv, 8'h00);
    end
    for (int n = 0; n < 3; n++) begin
      for (int p = 1; p < 7; p++) begin
        dv = (n == 0) ? 8'hff : $urandom();
        wd = $urandom();
        ev = $urandom();
        @(posedge mclk_i);
        ext[p] <= ev;
        reg_wr_rd(p, 2'h1, dv, rv);
        check("dir", rv, dv & msk(p));
        reg_wr_rd(p, 2'h2, wd, rv);
        check("data", rv, wd & msk(p));
        check("oe", pin_oe_o[p] & msk(p), dv & msk(p));
        check("pull-up", pullup_en_o[p] & msk(p), ~dv & wd & msk(p));
        reg_wr(p, 2'h0, ~rv);
        reg_rd(p, 2'h0, rv);
        check("sample", rv, ((dv & wd) | (~dv & ev)) & msk(p));
      end
    end
    // port a has only its sample byte
    @(posedge mclk_i);
    ext[0] <= wd;
    reg_rd(0, 2'h0, rv);
    check("port a sample", rv, wd);
    // floating port d pins: pull-ups on, then globally off
    reg_wr(3, 2'h1, 8'h00);
    reg_wr(3, 2'h2, 8'hff);
    ext_en[3] <= 8'h00;
    ext[3] <= 8'ha5;
    // the sample flop lags the pull-up flop by one cycle
    @(posedge mclk_i);
    reg_rd(3, 2'h0, rv);
    check("pulled level", rv, 8'hff);
    reg_wr(7, 2'h3, 8'h04);
    @(posedge mclk_i);
    reg_rd(3, 2'h0, rv);
    check("pud off", pullup_en_o[3], 8'h00);
    check("unpulled level", rv, 8'h5a);
    reg_rd(7, 2'h3, rv);
    check("control", rv, 8'h04);
    // legacy fuse with reset held: no clock edge in between
    @(posedge mclk_i);
    rst_i <= 1'b1;
    legacy_mode_i <= 1'b1;
    #1;
    check("legacy c oe", pin_oe_o[2], 8'hff);
    check("legacy c out", pin_out_o[2], 8'h00);
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    // port c registers left untouched here for backward compatibility
    for (int p = 5; p < 7; p++) begin
      for (int f = 0; f < 3; f++) begin
        reg_wr(p, f[1:0], 8'hff);
        reg_rd(p, f[1:0], rv);
        check("hidden reg", rv, (p == 5 && f == 0) ? ext[5] : 8'h00);
      end
    end
    check("f oe", pin_oe_o[5] | pullup_en_o[5], 8'h00);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk_i);
      {mem_ale_i, mem_rd_n_i, mem_wr_n_i} <= k[2:0];
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      check("g oe", pin_oe_o[6], 8'h07);
      check("g out", {5'h00, pin_out_o[6][2:0]}, {5'h00, k[2:0]});
    end
    check("c oe held", pin_oe_o[2], 8'hff);
    complete_run();
  end
endmodule // testbench
